// [design/hostctl_pkg.sv]
// shared constants for the host control and identification registers
package hostctl_pkg;

   // ==========================================================
   // register indices on the indirect window
   localparam logic [7:0] ADDR_HOST_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_PROTOCOL     = 8'h01;
   localparam logic [7:0] ADDR_VERSION      = 8'h02;
   localparam logic [7:0] ADDR_PART         = 8'h03;

   // ==========================================================
   // host control field positions
   localparam int BIT_SOFT_RESET  = 0;
   localparam int BIT_PROG_DONE   = 1;
   localparam int BIT_PORT1_BELL  = 2;
   localparam int BIT_PORT2_BELL  = 3;
   localparam int BIT_LOADED      = 4;
   localparam int POS_PORT1_MODE  = 5;
   localparam int POS_PORT2_MODE  = 7;
   localparam int BIT_CLKOUT_EN   = 9;
   localparam int BIT_BUF_LOCK    = 11;
   localparam int BIT_HOST_BELL   = 12;
   localparam int BIT_RMII_CLK_EN = 13;

   // ==========================================================
   // interface mode codes
   localparam logic [1:0] MODE_MII  = 2'h0;
   localparam logic [1:0] MODE_RMII = 2'h1;

   // ==========================================================
   // values after reset
   localparam logic [15:0] CONTROL_RESET  = 16'h0000;
   localparam logic [15:0] PROTOCOL_RESET = 16'h0000;

   // ==========================================================
   // clock divider periods at 125 MHz (8 ns)
   localparam int CLK_PERIOD_PS   = 8000;
   localparam int CLK25_PERIOD_PS = 40000;
   localparam int CLK50_PERIOD_PS = 20000;
   // 25 MHz from 125 MHz: 5 cycles, high 2, low 3
   localparam int CLK25_DIV = CLK25_PERIOD_PS / CLK_PERIOD_PS;
   // 50 MHz cannot be exact from 125 MHz; nearest even divide is 2 cycles
   localparam int CLK50_DIV = CLK50_PERIOD_PS / CLK_PERIOD_PS;

   // ==========================================================
   // firmware load duration in cycles
   localparam int LOAD_CYCLES = 64;

endpackage

// [design/gated_clk_div.sv]
// divider that makes a gated clock output, enable applied only while low
`timescale 1ns/10ps
module gated_clk_div #(
   parameter int DIV = 5
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic en_i,
   // clock output
   output logic      clk_o
);

   // ==========================================================
   // state
   logic [7:0] cnt_r;      // phase counter
   logic [7:0] cnt_nxt;
   logic       run_r;      // applied enable
   logic       run_nxt;
   logic       out_r;      // clock pin level
   logic       out_nxt;

   localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
   localparam logic [7:0] HIGH_LEN = 8'(DIV / 2);

   // next state: enable only changes when output is low so that
   // no short high pulse can ever leave the pin
   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      out_nxt = 1'b0;
      if (!out_r) begin
         run_nxt = en_i;
      end
      if (cnt_r == DIV_LAST) begin
         cnt_nxt = 8'h00;
      end else begin
         cnt_nxt = cnt_r + 8'h01;
      end
      // high for the first DIV/2 cycles, rounded down, of each period
      if (run_nxt && (cnt_nxt < HIGH_LEN)) begin
         out_nxt = 1'b1;
      end
      // restart the phase when gated off so the next burst is whole
      if (!run_nxt) begin
         cnt_nxt = DIV_LAST;
      end
   end

   // register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= DIV_LAST;
         run_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         out_r <= out_nxt;
      end
   end

   assign clk_o = out_r;

endmodule

// [design/switch_host_control_id_regs.sv]
// host control and identification register group of the switch
`timescale 1ns/10ps
module switch_host_control_id_regs #(
   parameter logic [4:0]  VERSION_NUM   = 5'h01,
   parameter logic [9:0]  MAKER_ID      = 10'h155, // arbitrary value
   parameter logic        VERSION_LSB   = 1'b1,
   parameter logic [15:0] PART_NUMBER   = 16'h1234, // arbitrary value
   parameter int          LOAD_CYCLES_P = hostctl_pkg::LOAD_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // indirect register window
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   output logic [15:0]      rdata_o,
   output logic             rvalid_o,
   // one-time protocol programming
   input  wire logic        otp_wr_i,
   input  wire logic [15:0] otp_data_i,
   // doorbells toward the protocol engines
   output logic             host_bell_o,
   output logic             port1_bell_o,
   output logic             port2_bell_o,
   // buffer lock gating
   output logic             resv_wr_allow_o,
   output logic             head_wr_allow_o,
   // interface modes
   output logic [1:0]       port1_mode_o,
   output logic [1:0]       port2_mode_o,
   output logic             port1_rmii_o,
   output logic             port2_rmii_o,
   // clock outputs
   output logic             clk25_o,
   output logic             clk50_o,
   // reset and firmware load
   output logic             soft_reset_o,
   output logic             fw_load_o
);
   import hostctl_pkg::*;

   // ==========================================================
   // load sequencer states
   typedef enum logic [2:0] {
      LD_IDLE = 3'b001,
      LD_BUSY = 3'b010,
      LD_DONE = 3'b100
   } load_e;

   // ==========================================================
   // state registers
   logic        prog_done_r;     // programming_done_flag
   logic        prog_done_nxt;
   logic        lock_r;          // buffer lock
   logic        lock_nxt;
   logic        clk_en_r;        // 25 MHz output enable
   logic        clk_en_nxt;
   logic        rmii_en_r;       // 50 MHz output enable
   logic        rmii_en_nxt;
   logic [1:0]  mode1_r;         // port 1 interface mode
   logic [1:0]  mode1_nxt;
   logic [1:0]  mode2_r;         // port 2 interface mode
   logic [1:0]  mode2_nxt;
   logic        hbell_r;         // doorbell pulses
   logic        hbell_nxt;
   logic        p1bell_r;
   logic        p1bell_nxt;
   logic        p2bell_r;
   logic        p2bell_nxt;
   logic        srst_r;          // soft_reset_bit pulse
   logic        srst_nxt;
   logic [15:0] proto_r;         // protocol register
   logic [15:0] proto_nxt;
   logic        proto_set_r;     // one-time write already used
   logic        proto_set_nxt;
   load_e       ld_r;
   load_e       ld_nxt;
   logic [15:0] ld_cnt_r;        // load progress counter
   logic [15:0] ld_cnt_nxt;
   logic        loaded_r;        // engines_loaded_status
   logic        loaded_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic        allow_r;         // lock gating image for the pins
   logic        allow_nxt;
   logic        rmii1_r;         // port 1 mode decode for the pin
   logic        rmii1_nxt;
   logic        rmii2_r;         // port 2 mode decode for the pin
   logic        rmii2_nxt;
   logic        busy_r;          // load in progress for the pin
   logic        busy_nxt;

   logic        wr_ctl;          // write to host control
   logic [15:0] ctl_view;        // host control as read back

   localparam logic [15:0] LOAD_LAST = 16'(LOAD_CYCLES_P - 1);

   assign wr_ctl = wr_i && (addr_i == ADDR_HOST_CONTROL);

   // read image; doorbells always read zero since the image leaves them out
   always_comb begin
      ctl_view                  = 16'h0000;
      ctl_view[BIT_PROG_DONE]   = prog_done_r;
      ctl_view[BIT_LOADED]      = loaded_r;
      ctl_view[POS_PORT1_MODE +: 2] = mode1_r;
      ctl_view[POS_PORT2_MODE +: 2] = mode2_r;
      ctl_view[BIT_CLKOUT_EN]   = clk_en_r;
      ctl_view[BIT_BUF_LOCK]    = lock_r;
      ctl_view[BIT_RMII_CLK_EN] = rmii_en_r;
   end

   // ==========================================================
   // control register next state
   always_comb begin
      prog_done_nxt = prog_done_r;
      lock_nxt      = lock_r;
      clk_en_nxt    = clk_en_r;
      rmii_en_nxt   = rmii_en_r;
      mode1_nxt     = mode1_r;
      mode2_nxt     = mode2_r;
      hbell_nxt     = 1'b0;
      p1bell_nxt    = 1'b0;
      p2bell_nxt    = 1'b0;
      srst_nxt      = 1'b0;
      if (wr_ctl) begin
         prog_done_nxt = wdata_i[BIT_PROG_DONE];
         lock_nxt      = wdata_i[BIT_BUF_LOCK];
         clk_en_nxt    = wdata_i[BIT_CLKOUT_EN];
         rmii_en_nxt   = wdata_i[BIT_RMII_CLK_EN];
         // undefined codes are stored as written; software must avoid
         mode1_nxt     = wdata_i[POS_PORT1_MODE +: 2];
         mode2_nxt     = wdata_i[POS_PORT2_MODE +: 2];
         hbell_nxt     = wdata_i[BIT_HOST_BELL];
         p1bell_nxt    = wdata_i[BIT_PORT1_BELL];
         p2bell_nxt    = wdata_i[BIT_PORT2_BELL];
         srst_nxt      = wdata_i[BIT_SOFT_RESET];
      end
      allow_nxt = !lock_nxt;
      rmii1_nxt = (mode1_nxt == MODE_RMII);
      rmii2_nxt = (mode2_nxt == MODE_RMII);
   end

   // register; soft reset returns control to its reset state
   always_ff @(posedge clk_i) begin
      if (rst_i || srst_r) begin
         prog_done_r <= CONTROL_RESET[BIT_PROG_DONE];
         lock_r      <= CONTROL_RESET[BIT_BUF_LOCK];
         clk_en_r    <= CONTROL_RESET[BIT_CLKOUT_EN];
         rmii_en_r   <= CONTROL_RESET[BIT_RMII_CLK_EN];
         mode1_r     <= MODE_MII;
         mode2_r     <= MODE_MII;
         hbell_r     <= 1'b0;
         p1bell_r    <= 1'b0;
         p2bell_r    <= 1'b0;
         allow_r     <= !CONTROL_RESET[BIT_BUF_LOCK];
         rmii1_r     <= 1'b0;
         rmii2_r     <= 1'b0;
      end else begin
         prog_done_r <= prog_done_nxt;
         lock_r      <= lock_nxt;
         clk_en_r    <= clk_en_nxt;
         rmii_en_r   <= rmii_en_nxt;
         mode1_r     <= mode1_nxt;
         mode2_r     <= mode2_nxt;
         hbell_r     <= hbell_nxt;
         p1bell_r    <= p1bell_nxt;
         p2bell_r    <= p2bell_nxt;
         allow_r     <= allow_nxt;
         rmii1_r     <= rmii1_nxt;
         rmii2_r     <= rmii2_nxt;
      end
   end

   // soft reset pulse itself only clears on the hard reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srst_r <= 1'b0;
      end else begin
         srst_r <= srst_nxt;
      end
   end

   // ==========================================================
   // one-time protocol register, survives soft reset like a fuse
   always_comb begin
      proto_nxt     = proto_r;
      proto_set_nxt = proto_set_r;
      if (otp_wr_i && !proto_set_r) begin
         proto_nxt     = otp_data_i;
         proto_set_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         proto_r     <= PROTOCOL_RESET;
         proto_set_r <= 1'b0;
      end else begin
         proto_r     <= proto_nxt;
         proto_set_r <= proto_set_nxt;
      end
   end

   // ==========================================================
   // firmware load sequencer
   always_comb begin
      ld_nxt     = ld_r;
      ld_cnt_nxt = ld_cnt_r;
      loaded_nxt = loaded_r;
      unique case (ld_r)
         LD_IDLE: begin
            // a write of one to the done flag, with the soft reset bit zero, kicks off the load
            if (wr_ctl && wdata_i[BIT_PROG_DONE] &&
                !wdata_i[BIT_SOFT_RESET]) begin
               ld_nxt     = LD_BUSY;
               ld_cnt_nxt = 16'h0000;
            end
         end
         LD_BUSY: begin
            if (ld_cnt_r == LOAD_LAST) begin
               ld_nxt     = LD_DONE;
               loaded_nxt = 1'b1;
            end else begin
               ld_cnt_nxt = ld_cnt_r + 16'h0001;
            end
         end
         LD_DONE: begin
            ld_nxt = LD_DONE;
         end
         default: begin
            ld_nxt = LD_IDLE;
         end
      endcase
      busy_nxt = (ld_nxt == LD_BUSY);
   end

   // soft reset drops loaded status; host must reprogram
   always_ff @(posedge clk_i) begin
      if (rst_i || srst_r) begin
         ld_r     <= LD_IDLE;
         ld_cnt_r <= 16'h0000;
         loaded_r <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         ld_r     <= ld_nxt;
         ld_cnt_r <= ld_cnt_nxt;
         loaded_r <= loaded_nxt;
         busy_r   <= busy_nxt;
      end
   end

   // ==========================================================
   // read port, data one cycle after the strobe
   always_comb begin
      rvalid_nxt = rd_i;
      rdata_nxt  = 16'h0000;
      if (rd_i) begin
         unique case (addr_i)
            ADDR_HOST_CONTROL: rdata_nxt = ctl_view;
            ADDR_PROTOCOL:     rdata_nxt = proto_r;
            ADDR_VERSION:      rdata_nxt = {VERSION_NUM, MAKER_ID,
                                            VERSION_LSB};
            ADDR_PART:         rdata_nxt = PART_NUMBER;
            default:           rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ==========================================================
   // gated clock outputs
   gated_clk_div #(.DIV(CLK25_DIV)) u_clk25 (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .en_i  (clk_en_r),
      .clk_o (clk25_o)
   );

   gated_clk_div #(.DIV(CLK50_DIV)) u_clk50 (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .en_i  (rmii_en_r),
      .clk_o (clk50_o)
   );

   // ==========================================================
   // output drive, all from flip-flops
   assign rdata_o         = rdata_r;
   assign rvalid_o        = rvalid_r;
   assign host_bell_o     = hbell_r;
   assign port1_bell_o    = p1bell_r;
   assign port2_bell_o    = p2bell_r;
   assign resv_wr_allow_o = allow_r;
   assign head_wr_allow_o = allow_r;
   assign port1_mode_o    = mode1_r;
   assign port2_mode_o    = mode2_r;
   assign port1_rmii_o    = rmii1_r;
   assign port2_rmii_o    = rmii2_r;
   assign soft_reset_o    = srst_r;
   assign fw_load_o       = busy_r;

endmodule

// [tb/hostctl_chk_sva.sv]
// assertion checker for the host control register group
`timescale 1ns/10ps
module hostctl_chk
   import hostctl_pkg::*;
#(
   parameter int LOAD_CYCLES_P = 4
) (
   // clock, reset and write side
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wr_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   // observed outputs
   input wire logic        host_bell_o,
   input wire logic        port1_bell_o,
   input wire logic        port2_bell_o,
   input wire logic        resv_wr_allow_o,
   input wire logic        head_wr_allow_o,
   input wire logic [1:0]  port1_mode_o,
   input wire logic [1:0]  port2_mode_o,
   input wire logic        port1_rmii_o,
   input wire logic        clk25_o,
   input wire logic        clk50_o,
   input wire logic        soft_reset_o,
   input wire logic        fw_load_o
);
   // ==========
   // helper logic
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] load_cnt_r;   // cycles spent loading
   logic [15:0] load_cnt_nxt;
   logic        ctl_wr;       // control write without soft reset
   assign ctl_wr = wr_i && addr_i == ADDR_HOST_CONTROL && !wdata_i[0];
   // count grows only while loading and clears otherwise, giving the load length at its end
   always_comb begin
      load_cnt_nxt = fw_load_o ? load_cnt_r + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_i) begin
      load_cnt_r <= rst_i ? 16'h0000 : load_cnt_nxt;
   end
   // ==========
   // properties
   chk_host_bell_pulse: assert property (
      ctl_wr && wdata_i[BIT_HOST_BELL] |=> host_bell_o ##1 !host_bell_o)
      else $error("host doorbell pulse wrong");
   chk_bell_zero_inert: assert property (
      ctl_wr && !wdata_i[BIT_HOST_BELL] |=> !host_bell_o)
      else $error("host doorbell fired on zero");
   chk_port_bells: assert property (
      ctl_wr |=> port1_bell_o == $past(wdata_i[BIT_PORT1_BELL])
              && port2_bell_o == $past(wdata_i[BIT_PORT2_BELL]))
      else $error("port doorbell mismatch");
   chk_lock_allow: assert property (
      ctl_wr |=> head_wr_allow_o == !$past(wdata_i[BIT_BUF_LOCK])
              && resv_wr_allow_o == head_wr_allow_o)
      else $error("lock gating mismatch");
   chk_mode_store: assert property (
      ctl_wr |=> port1_mode_o == $past(wdata_i[6:5])
              && port2_mode_o == $past(wdata_i[8:7])
              && port1_rmii_o == ($past(wdata_i[6:5]) == MODE_RMII))
      else $error("mode field mismatch");
   chk_load_start: assert property (
      $rose(fw_load_o) |-> $past(ctl_wr && wdata_i[BIT_PROG_DONE]))
      else $error("load began without done flag");
   chk_load_length: assert property (
      $fell(fw_load_o) && !$past(soft_reset_o)
         |-> load_cnt_r == LOAD_CYCLES_P)
      else $error("load length wrong");
   chk_soft_reset: assert property (
      wr_i && addr_i == ADDR_HOST_CONTROL && wdata_i[0] |=> soft_reset_o
         ##1 (!fw_load_o && head_wr_allow_o && port1_mode_o == MODE_MII))
      else $error("soft reset not applied");
   chk_clk25_high: assert property (
      $rose(clk25_o) |=> clk25_o ##1 !clk25_o)
      else $error("25 MHz high phase wrong");
   chk_clk50_high: assert property (
      $rose(clk50_o) |=> !clk50_o)
      else $error("fast clock high phase wrong");
   // ==========
   // coverage of main scenarios
   cov_load: cover property ($rose(fw_load_o));
   cov_reset: cover property (soft_reset_o);
   cov_clk: cover property ($rose(clk25_o));
endmodule

// [tb/host_model.sv]
// host processor model driving the indirect register window
`timescale 1ns/10ps
module host_model
   import hostctl_pkg::*;
(
   // clock
   input  wire logic        clk_i,
   // register window toward the device
   output logic             wr_o,
   output logic             rd_o,
   output logic [7:0]       addr_o,
   output logic [15:0]      wdata_o,
   input  wire logic [15:0] rdata_i,
   // one-time protocol programming
   output logic             otp_wr_o,
   output logic [15:0]      otp_data_o
);
   // ==========
   // idle levels at time zero
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      otp_wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 16'h0000;
      otp_data_o = 16'h0000;
   end
   // one write; released lines inverted so stale data never lingers
   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // one read; data taken in the cycle it stands
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
   // one-time protocol value strobe
   task automatic otp_prog(input logic [15:0] d);
      @(posedge clk_i);
      otp_wr_o <= 1'b1;
      otp_data_o <= d;
      @(posedge clk_i);
      otp_wr_o <= 1'b0;
      otp_data_o <= ~d;
   endtask
   // program memory lives elsewhere; only the done flag is sent here
   task automatic load_program();
      write_reg(ADDR_HOST_CONTROL, 16'h0002);
   endtask
endmodule

// [tb/switch_host_control_id_regs_tb.sv]
// self-checking bench for the host control register group
`timescale 1ns/10ps
module switch_host_control_id_regs_tb;
   import hostctl_pkg::*;
   // ==========
   // settings and wiring
   localparam int          LOAD  = 4;       // shortened firmware load
   localparam logic [4:0]  VER   = 5'h03;
   localparam logic [9:0]  MAKER = 10'h2a5; // arbitrary value
   localparam logic [15:0] PART  = 16'h5a5a; // arbitrary value
   logic        clk_i, rst_i, wr_i, rd_i, otp_wr_i, rvalid_o;
   logic [7:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, otp_data_i;
   logic        host_bell_o, port1_bell_o, port2_bell_o;
   logic        resv_wr_allow_o, head_wr_allow_o, port1_rmii_o, port2_rmii_o;
   logic [1:0]  port1_mode_o, port2_mode_o;
   logic        clk25_o, clk50_o, soft_reset_o, fw_load_o;
   int          err_total = 0;
   int          n_checks = 0;
   int          cycles = 0;    // hang guard
   switch_host_control_id_regs #(.VERSION_NUM(VER), .MAKER_ID(MAKER),
      .VERSION_LSB(1'b1), .PART_NUMBER(PART), .LOAD_CYCLES_P(LOAD)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .otp_wr_i(otp_wr_i), .otp_data_i(otp_data_i),
      .host_bell_o(host_bell_o), .port1_bell_o(port1_bell_o),
      .port2_bell_o(port2_bell_o), .resv_wr_allow_o(resv_wr_allow_o),
      .head_wr_allow_o(head_wr_allow_o), .port1_mode_o(port1_mode_o),
      .port2_mode_o(port2_mode_o), .port1_rmii_o(port1_rmii_o),
      .port2_rmii_o(port2_rmii_o), .clk25_o(clk25_o), .clk50_o(clk50_o),
      .soft_reset_o(soft_reset_o), .fw_load_o(fw_load_o));
   host_model u_host (.clk_i(clk_i), .wr_o(wr_i), .rd_o(rd_i),
      .addr_o(addr_i), .wdata_o(wdata_i), .rdata_i(rdata_o),
      .otp_wr_o(otp_wr_i), .otp_data_o(otp_data_i));
   // ==========
   // clock, guard and reporting
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         final_report();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic t_ids();
      logic [15:0] d;
      u_host.read_reg(ADDR_HOST_CONTROL, d);
      check(d, CONTROL_RESET);
      check({15'h0000, rvalid_o}, 16'h0001);
      u_host.read_reg(ADDR_VERSION, d);
      check(d, {VER, MAKER, 1'b1});
      u_host.read_reg(8'h2c, d);
      check(d, 16'h0000);
      u_host.write_reg(ADDR_PART, 16'hffff);
      u_host.read_reg(ADDR_PART, d);
      check(d, PART);
   endtask
   task automatic t_bells();
      int          pos [3] = '{BIT_PORT1_BELL, BIT_PORT2_BELL, BIT_HOST_BELL};
      logic [15:0] d;
      for (int i = 0; i < 3; i++) begin
         u_host.write_reg(ADDR_HOST_CONTROL, 16'h0001 << pos[i]);
         #1 check({13'h0, host_bell_o, port2_bell_o, port1_bell_o},
                  16'h0001 << i);
         @(posedge clk_i);
         #1 check({13'h0, host_bell_o, port2_bell_o, port1_bell_o},
                  16'h0000);
         u_host.read_reg(ADDR_HOST_CONTROL, d);
         check(d, 16'h0000);
      end
   endtask
   // lock with modes 01/10, then unlocked with modes 11/00
   task automatic t_lock_modes();
      logic [15:0] d;
      u_host.write_reg(ADDR_HOST_CONTROL, 16'h0920);
      #1 check({14'h0, resv_wr_allow_o, head_wr_allow_o}, 16'h0000);
      check({12'h0, port2_mode_o, port1_mode_o}, 16'h0009);
      check({14'h0, port2_rmii_o, port1_rmii_o}, 16'h0001);
      u_host.read_reg(ADDR_HOST_CONTROL, d);
      check(d, 16'h0920);
      u_host.write_reg(ADDR_HOST_CONTROL, 16'h0060);
      #1 check({14'h0, resv_wr_allow_o, head_wr_allow_o}, 16'h0003);
      check({12'h0, port2_mode_o, port1_mode_o}, 16'h0003);
      check({14'h0, port2_rmii_o, port1_rmii_o}, 16'h0000);
   endtask
   task automatic t_otp();
      logic [15:0] d;
      u_host.otp_prog(16'hb3c5);
      u_host.otp_prog(16'h1e2d);
      u_host.write_reg(ADDR_PROTOCOL, 16'h0000);
      u_host.read_reg(ADDR_PROTOCOL, d);
      check(d, 16'hb3c5);
   endtask
   // load length, loaded flag, refusal of a repeat
   task automatic t_load();
      logic [15:0] d;
      int          n;
      n = 0;
      u_host.load_program();
      #1;
      while (fw_load_o === 1'b1 && n < 100) begin
         n++;
         @(posedge clk_i);
         #1;
      end
      check(n[15:0], LOAD[15:0]);
      u_host.read_reg(ADDR_HOST_CONTROL, d);
      check(d & 16'h0010, 16'h0010);
      u_host.write_reg(ADDR_HOST_CONTROL, 16'h0002);
      #1 check({15'h0, fw_load_o}, 16'h0000);
   endtask
   task automatic t_soft_reset();
      logic [15:0] d;
      u_host.write_reg(ADDR_HOST_CONTROL, 16'h0820);
      u_host.write_reg(ADDR_HOST_CONTROL, 16'h0001);
      #1 check({15'h0, soft_reset_o}, 16'h0001);
      @(posedge clk_i);
      #1 check({12'h0, port1_mode_o, resv_wr_allow_o, head_wr_allow_o},
               16'h0003);
      u_host.read_reg(ADDR_HOST_CONTROL, d);
      check(d, 16'h0000);
      u_host.read_reg(ADDR_PROTOCOL, d);
      check(d, 16'hb3c5);
      t_load();
   endtask
   // edges counted over 50 cycles, enabled then disabled
   task automatic t_clocks();
      logic [7:0] r25, r50;
      logic       p25, p50;
      logic [15:0] d;
      for (int ph = 0; ph < 2; ph++) begin
         u_host.write_reg(ADDR_HOST_CONTROL, ph == 0 ? 16'h2200 : 16'h0000);
         // enables read back from the register, whatever the pin has applied so far
         u_host.read_reg(ADDR_HOST_CONTROL, d);
         check(d & 16'h2200, ph == 0 ? 16'h2200 : 16'h0000);
         repeat (10) @(posedge clk_i);
         #1;
         r25 = 8'h00;
         r50 = 8'h00;
         p25 = clk25_o;
         p50 = clk50_o;
         repeat (50) begin
            @(posedge clk_i);
            #1;
            r25 = r25 + {7'h00, clk25_o & ~p25};
            r50 = r50 + {7'h00, clk50_o & ~p50};
            p25 = clk25_o;
            p50 = clk50_o;
         end
         check({8'h00, r25}, ph == 0 ? 16'h000a : 16'h0000);
         check({8'h00, r50}, ph == 0 ? 16'h0019 : 16'h0000);
      end
   endtask
   // ==========
   // main sequence
   initial begin
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_ids();
      t_bells();
      t_lock_modes();
      t_otp();
      t_load();
      t_clocks();
      t_soft_reset();
      final_report();
   end
endmodule
bind switch_host_control_id_regs hostctl_chk #(
   .LOAD_CYCLES_P(LOAD_CYCLES_P)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .host_bell_o(host_bell_o),
   .port1_bell_o(port1_bell_o), .port2_bell_o(port2_bell_o),
   .resv_wr_allow_o(resv_wr_allow_o), .head_wr_allow_o(head_wr_allow_o),
   .port1_mode_o(port1_mode_o), .port2_mode_o(port2_mode_o),
   .port1_rmii_o(port1_rmii_o), .clk25_o(clk25_o), .clk50_o(clk50_o),
   .soft_reset_o(soft_reset_o), .fw_load_o(fw_load_o));
